// ==== rtl/cva_card_atr.sv ====
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - the card reports its classes one bit each in an interface byte, A in bit 0 up to E.
// - the reported class set is always contiguous, never with a hole between classes.
// - after every reset the card's first transmission is the answer-to-reset.
// - the answer-to-reset always carries the global interface bytes under T=15.
// - the first historical byte is the category indicator 80 for compact-TLV objects.
// - the historical objects start with card data service 31, then card capabilities 73.
// - the power limit holds until an application is selected; a status command counts only together with acc_ok.
module cva_card_atr #(
	parameter int ETU_CLKS = cva_pkg::ETU_CLKS,
	parameter int ATR_DELAY_CLKS = cva_pkg::ATR_DELAY_CLKS
) (
	// system
	input wire logic CLK_IN,
	input wire logic NRST_IN,
	// avalon-mm slave
	input wire logic [4:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	input wire logic [3:0] AVS_BYTEENABLE_IN,
	output logic [31:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT,
	// card contacts
	input wire logic CARD_CLK_IN,
	input wire logic CARD_RST_IN,
	input wire logic IO_IN,
	output logic IO_OUT,
	output logic IO_OE_OUT,
	// application events, power and interrupt
	input wire cva_pkg::cva_app_evt_type APP_EVT_IN,
	output logic PWR_LIMIT_OUT,
	output logic IRQ_OUT
);

	if (ETU_CLKS < 2 || ETU_CLKS > 4095 || ATR_DELAY_CLKS < 1 || ATR_DELAY_CLKS > 4095) begin : g_bad
		$error("cva_card_atr: card clock counts out of range");
	end

	localparam logic [11:0] ETU_LAST = 12'(ETU_CLKS - 1);
	localparam logic [11:0] DLY_LAST = 12'(ATR_DELAY_CLKS - 1);

	function automatic logic [4:0] contig(input logic [4:0] v);
		logic [4:0] low;
		logic [4:0] sum;
		low = v & (~v + 5'h01);
		sum = v + low;
		return ((sum & v) == 5'h00) ? v : low;
	endfunction

	function automatic logic [7:0] atr_byte(input logic [3:0] i, input logic [4:0] r,
		input logic [31:0] h, input logic [7:0] t);
		case (i)
			cva_pkg::IDX_TS: return cva_pkg::TS_DIRECT;
			cva_pkg::IDX_T0: return cva_pkg::T0_VAL;
			cva_pkg::IDX_TD1: return cva_pkg::TD1_VAL;
			cva_pkg::IDX_TD2: return cva_pkg::TD2_VAL;
			cva_pkg::IDX_TA3: return {3'h0, r};
			cva_pkg::IDX_CAT: return cva_pkg::CAT_IND;
			cva_pkg::IDX_DS: return cva_pkg::TAG_DS;
			cva_pkg::IDX_DSV: return h[7:0];
			cva_pkg::IDX_CAP: return cva_pkg::TAG_CAP;
			cva_pkg::IDX_C1: return h[15:8];
			cva_pkg::IDX_C2: return h[23:16];
			cva_pkg::IDX_C3: return h[31:24];
			default: return t;
		endcase
	endfunction

	logic [2:0] clk_s_q;
	logic [2:0] rst_s_q;
	logic [1:0] io_s_q;
	logic clk_edge;
	logic rst_lvl;
	logic rst_fall;
	cva_pkg::cva_state_type state_q;
	logic [11:0] cnt_q;
	logic [3:0] idx_q;
	logic [3:0] bit_q;
	logic [7:0] cur_q;
	logic [7:0] tck_q;
	logic [4:0] rep_q;
	logic [31:0] hl_q;
	logic [3:0] nxt_idx;
	logic [7:0] nxt_byte;
	logic go_send;
	logic etu_tick;
	logic byte_end;
	logic last;
	logic io_out_q;
	logic io_oe_q;
	logic lim_q;
	logic sel_evt;
	logic [4:0] class_q;
	logic [31:0] hist_q;
	logic [2:0] status_q;
	logic [2:0] mask_q;
	logic [2:0] st_set;
	logic [2:0] st_clr;
	logic irq_q;
	logic ack_q;
	logic req;
	logic wr;
	logic [31:0] rd_q;

	// card pins come from the terminal's domain; stage 0 feeds only stage 1
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			clk_s_q <= 3'h0;
			rst_s_q <= 3'h0;
			io_s_q <= 2'h3;
		end else begin
			clk_s_q <= {clk_s_q[1:0], CARD_CLK_IN};
			rst_s_q <= {rst_s_q[1:0], CARD_RST_IN};
			io_s_q <= {io_s_q[0], IO_IN};
		end
	end

	assign clk_edge = clk_s_q[1] & ~clk_s_q[2];
	assign rst_lvl = rst_s_q[1];
	assign rst_fall = rst_s_q[2] & ~rst_s_q[1];

	assign go_send = (state_q == cva_pkg::S_WAIT) && clk_edge && (cnt_q == DLY_LAST);
	assign etu_tick = (state_q == cva_pkg::S_SEND) && clk_edge && (cnt_q == ETU_LAST);
	assign byte_end = etu_tick && (bit_q == cva_pkg::BIT_LAST);
	assign last = byte_end && (idx_q == cva_pkg::IDX_TCK);
	assign nxt_idx = idx_q + 4'h1;
	assign nxt_byte = atr_byte(nxt_idx, rep_q, hl_q, tck_q);

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			state_q <= cva_pkg::S_IDLE;
		end else if (!rst_lvl) begin
			state_q <= cva_pkg::S_IDLE;
		end else begin
			case (state_q)
				cva_pkg::S_IDLE: state_q <= cva_pkg::S_WAIT;
				cva_pkg::S_WAIT: if (go_send) state_q <= cva_pkg::S_SEND;
				cva_pkg::S_SEND: if (last) state_q <= cva_pkg::S_DONE;
				cva_pkg::S_DONE: state_q <= cva_pkg::S_DONE;
				default: state_q <= cva_pkg::S_IDLE;
			endcase
		end
	end

	// counts card clock edges, both for the start delay and for each etu
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			cnt_q <= 12'h000;
		end else if (!rst_lvl || state_q == cva_pkg::S_IDLE || go_send || etu_tick) begin
			cnt_q <= 12'h000;
		end else if (clk_edge) begin
			cnt_q <= cnt_q + 12'h001;
		end
	end

	// contents latched at start so a register write cannot tear an answer
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			idx_q <= 4'h0;
			bit_q <= 4'h0;
			cur_q <= 8'h00;
			tck_q <= 8'h00;
			rep_q <= 5'h00;
			hl_q <= 32'h0000_0000;
		end else if (go_send) begin
			idx_q <= cva_pkg::IDX_TS;
			bit_q <= 4'h0;
			rep_q <= contig(class_q);
			hl_q <= hist_q;
			tck_q <= 8'h00;
			cur_q <= cva_pkg::TS_DIRECT;
		end else if (byte_end && !last) begin
			idx_q <= nxt_idx;
			bit_q <= 4'h0;
			cur_q <= nxt_byte;
			if (nxt_idx != cva_pkg::IDX_TCK) begin
				tck_q <= tck_q ^ nxt_byte;
			end
		end else if (etu_tick) begin
			bit_q <= bit_q + 4'h1;
		end
	end

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			io_oe_q <= 1'h0;
			io_out_q <= 1'h1;
		end else if (!rst_lvl || last) begin
			io_oe_q <= 1'h0;
			io_out_q <= 1'h1;
		end else if (go_send || byte_end) begin
			io_oe_q <= 1'h1;
			io_out_q <= 1'h0;
		end else if (etu_tick) begin
			if (bit_q < 4'h8) begin
				io_oe_q <= 1'h1;
				io_out_q <= cur_q[bit_q[2:0]];
			end else if (bit_q == 4'h8) begin
				io_oe_q <= 1'h1;
				io_out_q <= ^cur_q;
			end else begin
				// guard time: line released to the pull-up
				io_oe_q <= 1'h0;
				io_out_q <= 1'h1;
			end
		end
	end

	assign sel_evt = APP_EVT_IN.acc_ok
		| (APP_EVT_IN.no_acc & APP_EVT_IN.app_cmd & ~APP_EVT_IN.status_cmd);

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			lim_q <= 1'h1;
		end else if (!rst_lvl) begin
			lim_q <= 1'h1;
		end else if (sel_evt) begin
			lim_q <= 1'h0;
		end
	end

	// one wait state: readdata is loaded while waitrequest is high
	assign req = AVS_READ_IN | AVS_WRITE_IN;
	assign AVS_WAITREQUEST_OUT = req & ~ack_q;
	assign wr = AVS_WRITE_IN & ack_q;

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			ack_q <= 1'h0;
			rd_q <= 32'h0000_0000;
		end else begin
			ack_q <= req & ~ack_q;
			if (AVS_READ_IN && !ack_q) begin
				case (AVS_ADDRESS_IN)
					cva_pkg::ADDR_CLASS: rd_q <= 32'(class_q);
					cva_pkg::ADDR_HIST: rd_q <= hist_q;
					cva_pkg::ADDR_STATUS: rd_q <= 32'(status_q);
					cva_pkg::ADDR_MASK: rd_q <= 32'(mask_q);
					cva_pkg::ADDR_STATE: begin
						rd_q <= 32'h0000_0000;
						rd_q[cva_pkg::SR_LIMIT] <= lim_q;
						rd_q[cva_pkg::SR_BUSY] <= state_q == cva_pkg::S_SEND;
						rd_q[cva_pkg::SR_DONE] <= state_q == cva_pkg::S_DONE;
						rd_q[cva_pkg::SR_CRST] <= rst_lvl;
						rd_q[cva_pkg::SR_IO] <= io_s_q[1];
					end
					default: rd_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			class_q <= cva_pkg::CLASS_RST;
			hist_q <= cva_pkg::HIST_RST;
			mask_q <= cva_pkg::MASK_RST;
		end else if (wr) begin
			if (AVS_ADDRESS_IN == cva_pkg::ADDR_CLASS && AVS_BYTEENABLE_IN[0]) begin
				class_q <= AVS_WRITEDATA_IN[4:0];
			end
			if (AVS_ADDRESS_IN == cva_pkg::ADDR_MASK && AVS_BYTEENABLE_IN[0]) begin
				mask_q <= AVS_WRITEDATA_IN[2:0];
			end
			for (int b = 0; b < 4; b++) begin
				if (AVS_ADDRESS_IN == cva_pkg::ADDR_HIST && AVS_BYTEENABLE_IN[b]) begin
					hist_q[8*b +: 8] <= AVS_WRITEDATA_IN[8*b +: 8];
				end
			end
		end
	end

	// set wins over a same-cycle write-one-to-clear
	always_comb begin
		st_set = 3'h0;
		st_set[cva_pkg::ST_DONE] = last;
		st_set[cva_pkg::ST_SEL] = lim_q & sel_evt & rst_lvl;
		st_set[cva_pkg::ST_RST] = rst_fall;
		st_clr = 3'h0;
		if (wr && AVS_ADDRESS_IN == cva_pkg::ADDR_STATUS && AVS_BYTEENABLE_IN[0]) begin
			st_clr = AVS_WRITEDATA_IN[2:0];
		end
	end

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			status_q <= 3'h0;
			irq_q <= 1'h0;
		end else begin
			status_q <= (status_q & ~st_clr) | st_set;
			irq_q <= |(status_q & mask_q);
		end
	end

	assign AVS_READDATA_OUT = rd_q;
	assign IO_OUT = io_out_q;
	assign IO_OE_OUT = io_oe_q;
	assign PWR_LIMIT_OUT = lim_q;
	assign IRQ_OUT = irq_q;

	logic [4:0] rep_low;
	logic [4:0] rep_sum;
	assign rep_low = rep_q & (~rep_q + 5'h01);
	assign rep_sum = rep_q + rep_low;

	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!NRST_IN);

	sequence s_byte(logic [3:0] i);
		state_q == cva_pkg::S_SEND && idx_q == i && bit_q == 4'h0;
	endsequence

	property p_atr_first;
		(state_q == cva_pkg::S_SEND && $past(state_q) == cva_pkg::S_WAIT)
			|-> idx_q == cva_pkg::IDX_TS && io_oe_q && !io_out_q && cur_q == cva_pkg::TS_DIRECT;
	endproperty
	a_atr_first: assert property (p_atr_first) else $error("answer does not open with TS");

	property p_quiet;
		state_q != cva_pkg::S_SEND |=> !io_oe_q || $past(go_send);
	endproperty
	a_quiet: assert property (p_quiet) else $error("io driven outside the answer");

	property p_class;
		s_byte(cva_pkg::IDX_TA3) |-> cur_q == {3'h0, rep_q};
	endproperty
	a_class: assert property (p_class) else $error("class byte wrong");

	property p_contig;
		state_q == cva_pkg::S_SEND |-> (rep_sum & rep_q) == 5'h00;
	endproperty
	a_contig: assert property (p_contig) else $error("class set has a hole");

	property p_global;
		s_byte(cva_pkg::IDX_TD2) |-> cur_q == cva_pkg::TD2_VAL && cur_q[3:0] == 4'hF;
	endproperty
	a_global: assert property (p_global) else $error("T=15 indicator missing");

	property p_cat;
		s_byte(cva_pkg::IDX_CAT) |-> cur_q == cva_pkg::CAT_IND;
	endproperty
	a_cat: assert property (p_cat) else $error("category indicator wrong");

	property p_tags;
		(s_byte(cva_pkg::IDX_DS) |-> cur_q == cva_pkg::TAG_DS)
			and (s_byte(cva_pkg::IDX_CAP) |-> cur_q == cva_pkg::TAG_CAP);
	endproperty
	a_tags: assert property (p_tags) else $error("historical object order wrong");

	property p_limit;
		$fell(lim_q) |-> $past(sel_evt) && $past(rst_lvl);
	endproperty
	a_limit: assert property (p_limit) else $error("power limit lifted without selection");

endmodule

`default_nettype wire

// ==== rtl/cva_pkg.sv ====
package cva_pkg;

	// register byte offsets
	localparam logic [4:0] ADDR_CLASS = 5'h00;
	localparam logic [4:0] ADDR_HIST = 5'h04;
	localparam logic [4:0] ADDR_STATUS = 5'h08;
	localparam logic [4:0] ADDR_MASK = 5'h0C;
	localparam logic [4:0] ADDR_STATE = 5'h10;

	// reset values
	localparam logic [4:0] CLASS_RST = 5'h06;
	localparam logic [31:0] HIST_RST = 32'h0000_00A0;
	localparam logic [2:0] MASK_RST = 3'h0;

	// status bit positions
	localparam int ST_DONE = 0;
	localparam int ST_SEL = 1;
	localparam int ST_RST = 2;
	localparam int ST_W = 3;

	// state register bit positions
	localparam int SR_LIMIT = 0;
	localparam int SR_BUSY = 1;
	localparam int SR_DONE = 2;
	localparam int SR_CRST = 3;
	localparam int SR_IO = 4;

	// timing: clock counts in card clock cycles, BIT_LAST as the last etu of a character
	localparam int ETU_CLKS = 372;
	localparam int ATR_DELAY_CLKS = 400;
	localparam logic [3:0] BIT_LAST = 4'hB;

	// answer-to-reset byte positions
	localparam logic [3:0] IDX_TS = 4'h0;
	localparam logic [3:0] IDX_T0 = 4'h1;
	localparam logic [3:0] IDX_TD1 = 4'h2;
	localparam logic [3:0] IDX_TD2 = 4'h3;
	localparam logic [3:0] IDX_TA3 = 4'h4;
	localparam logic [3:0] IDX_CAT = 4'h5;
	localparam logic [3:0] IDX_DS = 4'h6;
	localparam logic [3:0] IDX_DSV = 4'h7;
	localparam logic [3:0] IDX_CAP = 4'h8;
	localparam logic [3:0] IDX_C1 = 4'h9;
	localparam logic [3:0] IDX_C2 = 4'hA;
	localparam logic [3:0] IDX_C3 = 4'hB;
	localparam logic [3:0] IDX_TCK = 4'hC;

	// answer-to-reset fixed bytes
	localparam logic [7:0] TS_DIRECT = 8'h3B;
	localparam logic [7:0] T0_VAL = 8'h87;
	localparam logic [7:0] TD1_VAL = 8'h80;
	localparam logic [7:0] TD2_VAL = 8'h1F;
	localparam logic [7:0] CAT_IND = 8'h80;
	localparam logic [7:0] TAG_DS = 8'h31;
	localparam logic [7:0] TAG_CAP = 8'h73;

	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_WAIT = 4'b0010,
		S_SEND = 4'b0100,
		S_DONE = 4'b1000
	} cva_state_type;

	typedef struct packed {
		logic acc_ok;
		logic no_acc;
		logic app_cmd;
		logic status_cmd;
	} cva_app_evt_type;

endpackage

// ==== tb/cva_card_atr_test.sv ====
`timescale 1ns/100ps
`default_nettype none

module cva_card_atr_test;
	logic clk, nrst, rd, wr, waitreq, io_out, io_oe, io_line, card_clk, card_rst, pwr_limit, irq;
	logic [4:0] addr;
	logic [31:0] wdata, rdata;
	logic [3:0] be;
	cva_pkg::cva_app_evt_type evt;
	int bad_count = 0;
	int samples_checked = 0;
	int cycles = 0;

	cva_card_atr #(.ETU_CLKS(4), .ATR_DELAY_CLKS(2)) u_dut (
		.CLK_IN(clk), .NRST_IN(nrst), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
		.AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be),
		.AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq), .CARD_CLK_IN(card_clk),
		.CARD_RST_IN(card_rst), .IO_IN(io_line), .IO_OUT(io_out), .IO_OE_OUT(io_oe),
		.APP_EVT_IN(evt), .PWR_LIMIT_OUT(pwr_limit), .IRQ_OUT(irq));
	cva_term_model #(.ETU(4), .WAIT_LIMIT(1000)) u_term (
		.io_out_in(io_out), .io_oe_in(io_oe), .card_clk_out(card_clk),
		.card_rst_out(card_rst), .io_line_out(io_line));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// a hang is cut short well past the longest run
	always @(posedge clk) begin
		cycles++;
		if (cycles == 90000) begin
			bad_count++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wait_ack();
		int n;
		n = 0;
		// waitrequest is judged at the rising edge, before that edge's updates land
		@(posedge clk);
		while (waitreq !== 1'b0 && n < 20) begin
			@(posedge clk);
			n++;
		end
		check("waitrequest", 32'h0, {31'h0, waitreq});
	endtask
	task automatic bus_wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		be <= b;
		wr <= 1'b1;
		wait_ack();
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input string what, input logic [4:0] a, input logic [31:0] exp,
		input logic [31:0] m);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		wait_ack();
		check(what, exp, rdata & m);
		rd <= 1'b0;
	endtask
	task automatic test_regs();
		rd_chk("class", cva_pkg::ADDR_CLASS, 32'h6, 32'h1F);
		rd_chk("hist", cva_pkg::ADDR_HIST, 32'hA0, 32'hFFFF_FFFF);
		rd_chk("mask", cva_pkg::ADDR_MASK, 32'h0, 32'h7);
		rd_chk("limit", cva_pkg::ADDR_STATE, 32'h1, 32'h1);
		bus_wr(5'h14, 32'hFFFF_FFFF, 4'hF);
		rd_chk("unmapped", 5'h14, 32'h0, 32'hFFFF_FFFF);
		bus_wr(cva_pkg::ADDR_HIST, 32'hFFFF_FFFF, 4'h2);
		rd_chk("hist lane", cva_pkg::ADDR_HIST, 32'h0000_FFA0, 32'hFFFF_FFFF);
	endtask
	task automatic test_atr(input logic [4:0] cw, input logic [7:0] ta3, input logic [7:0] ec);
		logic [7:0] exp[13];
		logic [7:0] cls;
		exp = '{8'h3B, 8'h87, 8'h80, 8'h1F, ta3, 8'h80, 8'h31, 8'h11, 8'h73, 8'h22, 8'h33,
			8'h44, 8'h00};
		for (int i = 1; i < 12; i++)
			exp[12] ^= exp[i];
		bus_wr(cva_pkg::ADDR_CLASS, {27'h0, cw}, 4'h1);
		bus_wr(cva_pkg::ADDR_HIST, 32'h4433_2211, 4'hF);
		u_term.session(cls);
		check("applied class", {24'h0, ec}, {24'h0, cls});
		check("chars", 32'd13, u_term.rx.size());
		check("wire faults", 32'h0, u_term.par_err);
		for (int i = 0; i < 13; i++)
			check("answer byte", {24'h0, exp[i]}, {24'h0, u_term.rx[i]});
		u_term.power_down();
		rd_chk("status", cva_pkg::ADDR_STATUS, 32'h5, 32'h7);
		check("irq masked", 32'h0, {31'h0, irq});
		bus_wr(cva_pkg::ADDR_MASK, 32'h1, 4'h1);
		repeat (3) @(negedge clk);
		check("irq raised", 32'h1, {31'h0, irq});
		bus_wr(cva_pkg::ADDR_STATUS, 32'h7, 4'h1);
		bus_wr(cva_pkg::ADDR_MASK, 32'h0, 4'h1);
		repeat (3) @(negedge clk);
		check("irq cleared", 32'h0, {31'h0, irq});
		rd_chk("status clear", cva_pkg::ADDR_STATUS, 32'h0, 32'h7);
	endtask
	task automatic pulse(input logic [3:0] v, input logic lim);
		@(posedge clk);
		evt <= v;
		@(posedge clk);
		evt <= 4'h0;
		repeat (2) @(negedge clk);
		check("power limit", {31'h0, lim}, {31'h0, pwr_limit});
	endtask
	task automatic test_power();
		u_term.power_up();
		pulse(4'b0001, 1'b1);
		pulse(4'b0111, 1'b1);
		pulse(4'b0110, 1'b0);
		rd_chk("selected", cva_pkg::ADDR_STATUS, 32'h3, 32'h3);
		u_term.power_down();
		check("limit again", 32'h1, {31'h0, pwr_limit});
		u_term.power_up();
		pulse(4'b1000, 1'b0);
		u_term.power_down();
	endtask

	initial begin
		nrst = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		addr = 5'h00;
		wdata = 32'h0;
		be = 4'h0;
		evt = 4'h0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		test_regs();
		test_atr(5'h06, 8'h06, 8'h04);
		test_atr(5'h01, 8'h01, 8'h01);
		test_atr(5'h05, 8'h01, 8'h01);
		test_power();
		print_verdict();
	end
endmodule

`default_nettype wire

// ==== tb/cva_term_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module cva_term_model #(
	parameter int ETU = 4,
	parameter int WAIT_LIMIT = 1000
) (
	// card drive
	input wire logic io_out_in,
	input wire logic io_oe_in,
	// terminal drive
	output logic card_clk_out,
	output logic card_rst_out,
	output logic io_line_out
);
	logic run = 1'b0;
	logic busy = 1'b0;
	logic [7:0] sh;
	int cnt;
	int par_err;
	logic [7:0] rx[$];
	// pull-up wins whenever the card lets go of the line
	assign io_line_out = io_oe_in ? io_out_in : 1'b1;
	// clock stands still while the card is powered down
	initial begin
		card_clk_out = 1'b0;
		card_rst_out = 1'b0;
		forever #400 card_clk_out = run & ~card_clk_out;
	end
	always @(posedge card_clk_out) begin
		if (!busy && !io_line_out) begin
			busy = 1'b1;
			cnt = 0;
		end else if (busy) begin
			cnt++;
			if (cnt % ETU == 0 && cnt < 9 * ETU)
				sh[cnt / ETU - 1] = io_line_out;
			if (cnt == 9 * ETU) begin
				par_err += int'(^{sh, io_line_out});
				rx.push_back(sh);
			end
			// driving in the guard time is a wire fault too
			if (cnt == 10 * ETU && io_oe_in)
				par_err++;
			if (cnt == 11 * ETU)
				busy = 1'b0;
		end
	end
	task automatic power_up();
		rx.delete();
		par_err = 0;
		run = 1'b1;
		repeat (4) @(posedge card_clk_out);
		card_rst_out = 1'b1;
		repeat (WAIT_LIMIT) if (rx.size() < 13) @(posedge card_clk_out);
		// let the last guard time run out so the card finishes its answer
		repeat (12 * ETU) @(posedge card_clk_out);
	endtask
	task automatic power_down();
		card_rst_out = 1'b0;
		repeat (4) @(posedge card_clk_out);
		run = 1'b0;
	endtask
	task automatic session(output logic [7:0] cls);
		int bad_run;
		bad_run = 0;
		// start at the lowest voltage, class C
		cls = 8'h04;
		for (int a = 0; a < 8; a++) begin
			power_up();
			if (rx.size() < 13)
				cls = cls >> 1;
			// three corrupted answers, then next higher only
			else if (par_err != 0) begin
				bad_run++;
				if (bad_run == 3)
					cls = cls >> 1;
			end
			else if ((rx[4] & cls) == 8'h00)
				cls = rx[4][2] ? 8'h04 : (rx[4][1] ? 8'h02 : 8'h01);
			else
				break;
			power_down();
			if (cls == 8'h00)
				break;
		end
	endtask
endmodule

`default_nettype wire
